// [hdl/clkctl_pkg.sv]
// Constants and carrier types for the system clock select and prescaler block
package clkctl_pkg;

   // Clock rate of the block itself
   localparam int CLOCK_PERIOD_NS = 50;

   // Prescale register placement and fields
   localparam logic [7:0] PRESCALE_OFFSET = 8'h00;
   localparam int PCE_BIT = 7;
   localparam logic [7:0] UNLOCK_VALUE = 8'h80;
   localparam logic [3:0] SEL_RESET_DIV1 = 4'h0;
   localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
   localparam logic [3:0] SEL_MAX = 4'h8;
   localparam logic [2:0] PCE_WINDOW = 3'h4;

   // Clock source and start-up fuse codes
   localparam logic [3:0] SRC_EXTERNAL = 4'h0;
   localparam logic [3:0] SRC_LOW_POWER = 4'h6;
   localparam logic [1:0] SUT_SHORT = 2'h0;
   localparam logic [1:0] SUT_FAST = 2'h1;
   localparam logic [1:0] SUT_SLOW = 2'h2;
   localparam logic [1:0] SUT_RESERVED = 2'h3;

   // Start-up counts in source clock cycles
   localparam logic [3:0] RESET_TICKS = 4'hE;
   localparam logic [3:0] WAKE_TICKS = 4'h6;

   // Additional reset delays, in microseconds, and their clock cycle counts
   localparam int EXT_FAST_US = 4100;
   localparam int EXT_SLOW_US = 65000;
   localparam int LP_FAST_US = 4000;
   localparam int LP_SLOW_US = 64000;
   localparam int EXT_FAST_CYC = (EXT_FAST_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int EXT_SLOW_CYC = (EXT_SLOW_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int LP_FAST_CYC = (LP_FAST_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int LP_SLOW_CYC = (LP_SLOW_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int DELAY_W = 21;

   // Fuse straps, register request and divided clock ticks
   typedef struct packed {
      logic [3:0] source_sel;
      logic [1:0] startup_sel;
      logic div8_programmed;
   } fuse_cfg_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic io_tick;
      logic cpu_tick;
      logic flash_tick;
   } clk_ticks_t;

endpackage : clkctl_pkg

// [hdl/power2_divider.sv]
// Power-of-two divider with switching held to whole old periods
`timescale 1ns/1ps
`default_nettype none
module power2_divider import clkctl_pkg::*; #(
   parameter int SEL_W = 4,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Source ticks and setting control
   input wire logic run,
   input wire logic src_tick,
   input wire logic load_init,
   input wire logic [SEL_W-1:0] init_sel,
   input wire logic new_valid,
   input wire logic [SEL_W-1:0] new_sel,
   // Divided clock
   output logic div_tick,
   output logic [SEL_W-1:0] active_sel,
   output logic switch_busy
);

   logic [CNT_W-1:0] cnt_q;
   logic [SEL_W-1:0] act_q;
   logic [SEL_W-1:0] pend_sel_q;
   logic pend_q;
   logic tick_q;
   logic [CNT_W-1:0] mask;
   logic boundary;

   // Period end of the setting in force
   assign mask = CNT_W'((32'h1 << act_q) - 32'h1);
   assign boundary = run && src_tick && (cnt_q == mask);
   assign div_tick = tick_q;
   assign active_sel = act_q;
   assign switch_busy = pend_q;

   // Counter advanced by undivided source ticks; a new setting lands only at a period end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         act_q <= '0;
         pend_sel_q <= '0;
         pend_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= boundary;
         if (load_init) begin
            cnt_q <= '0;
            act_q <= init_sel;
            pend_q <= 1'b0;
         end else begin
            if (boundary) begin
               cnt_q <= '0;
               if (pend_q) begin
                  act_q <= pend_sel_q;
               end
               pend_q <= 1'b0;
            end else if (run && src_tick) begin
               cnt_q <= cnt_q + CNT_W'(1);
            end
            if (new_valid) begin
               pend_q <= 1'b1;
               pend_sel_q <= new_sel;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_hold_mid_period: assert property (@(posedge clock) disable iff (rst)
      !boundary && !load_init |=> act_q == $past(act_q))
      else $error("setting changed inside a divided period");
   chk_switch_boundary: assert property (@(posedge clock) disable iff (rst)
      pend_q && boundary && !load_init |=> act_q == $past(pend_sel_q) ##0 cnt_q == '0)
      else $error("pending setting not applied at period end");

endmodule : power2_divider
`default_nettype wire

// [hdl/system_clock_select_prescaler.sv]
// System clock source selection, start-up delays and software prescaler
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_prescaler import clkctl_pkg::*; #(
   parameter int EXT_FAST_DELAY = EXT_FAST_CYC,
   parameter int EXT_SLOW_DELAY = EXT_SLOW_CYC,
   parameter int LP_FAST_DELAY = LP_FAST_CYC,
   parameter int LP_SLOW_DELAY = LP_SLOW_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Fuse straps
   input wire fuse_cfg_t fuses,
   // Clock sources, sampled on clock
   input wire logic ext_clock_pin,
   input wire logic low_power_osc,
   // Sleep control
   input wire logic power_down,
   // Register port
   input wire reg_req_t bus,
   output logic [7:0] reg_rdata,
   // Divided clock ticks and status
   output clk_ticks_t sys_ticks,
   output logic clock_running,
   output logic config_error,
   output logic [3:0] active_sel
);

   typedef enum logic [2:0] {
      ST_CAPTURE,
      ST_RESET_TICKS,
      ST_EXTRA,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE,
      ST_HALT
   } clk_state_t;

   clk_state_t st_q;
   clk_state_t st_d;
   fuse_cfg_t cfg_q;
   logic src_prev_q;
   logic [3:0] tick_cnt_q;
   logic [3:0] tick_cnt_d;
   logic [DELAY_W-1:0] delay_q;
   logic [DELAY_W-1:0] delay_d;
   logic pce_q;
   logic [2:0] pce_timer_q;
   logic [3:0] sel_q;
   logic [7:0] rdata_q;
   logic div_tick;
   logic switch_busy;

   ////////////////////////////////////////////////////////////////////////////////
   // Source selection and tick detection

   logic use_lp;
   logic src_level;
   logic cap_level;
   logic src_tick;
   logic cfg_ok;
   logic [DELAY_W-1:0] extra_cycles;

   // Fuse code picks which sampled source drives the prescaler
   assign use_lp = (cfg_q.source_sel == SRC_LOW_POWER);
   assign src_level = use_lp ? low_power_osc : ext_clock_pin;
   assign src_tick = src_level && !src_prev_q;
   assign cap_level = (fuses.source_sel == SRC_LOW_POWER) ? low_power_osc : ext_clock_pin;
   assign cfg_ok = ((cfg_q.source_sel == SRC_EXTERNAL) || use_lp)
                   && (cfg_q.startup_sel != SUT_RESERVED);

   // Additional reset delay after the 14 source cycles
   assign extra_cycles = (cfg_q.startup_sel == SUT_FAST)
      ? (use_lp ? DELAY_W'(LP_FAST_DELAY) : DELAY_W'(EXT_FAST_DELAY))
      : (use_lp ? DELAY_W'(LP_SLOW_DELAY) : DELAY_W'(EXT_SLOW_DELAY));

   // Previous source level for edge detection
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         src_prev_q <= 1'b0;
      end else if (st_q == ST_CAPTURE) begin
         src_prev_q <= cap_level; // Seed from the strapped source, no false first edge
      end else begin
         src_prev_q <= src_level;
      end
   end

   // Fuse straps caught once, in the first cycle after reset release
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_q <= '0;
      end else if (st_q == ST_CAPTURE) begin
         cfg_q <= fuses;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Start-up and wake sequencing

   // Next state and counters
   always_comb begin
      st_d = st_q;
      tick_cnt_d = tick_cnt_q;
      delay_d = delay_q;
      case (st_q)
         ST_CAPTURE: begin
            st_d = ST_RESET_TICKS;
            tick_cnt_d = '0;
         end
         ST_RESET_TICKS: begin
            if (!cfg_ok) begin
               st_d = ST_HALT;
            end else if (src_tick) begin
               tick_cnt_d = tick_cnt_q + 4'h1;
               if (tick_cnt_q == RESET_TICKS - 4'h1) begin
                  tick_cnt_d = '0;
                  delay_d = extra_cycles;
                  st_d = (cfg_q.startup_sel == SUT_SHORT) ? ST_RUN : ST_EXTRA;
               end
            end
         end
         ST_EXTRA: begin
            delay_d = delay_q - DELAY_W'(1);
            if (delay_q <= DELAY_W'(1)) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (power_down) begin
               st_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            tick_cnt_d = '0;
            if (!power_down) begin
               st_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (src_tick) begin
               tick_cnt_d = tick_cnt_q + 4'h1;
               if (tick_cnt_q == WAKE_TICKS - 4'h1) begin
                  tick_cnt_d = '0;
                  st_d = ST_RUN;
               end
            end
         end
         default: begin
            st_d = ST_HALT;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= ST_CAPTURE;
         tick_cnt_q <= '0;
         delay_q <= '0;
      end else begin
         st_q <= st_d;
         tick_cnt_q <= tick_cnt_d;
         delay_q <= delay_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescale register

   logic wr_hit;
   logic rd_hit;
   logic unlock_hit;
   logic pce_set;
   logic sel_write;
   logic sel_accept;

   // Write decode; the unlock only counts with every other bit zero
   assign wr_hit = bus.write && (bus.addr == PRESCALE_OFFSET) && (st_q != ST_CAPTURE);
   assign rd_hit = bus.read && (bus.addr == PRESCALE_OFFSET);
   assign unlock_hit = wr_hit && (bus.wdata == UNLOCK_VALUE);
   assign pce_set = unlock_hit && !pce_q;
   assign sel_write = wr_hit && pce_q && !bus.wdata[PCE_BIT];
   assign sel_accept = sel_write && (bus.wdata[3:0] <= SEL_MAX);

   // Change enable with its four-cycle window
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pce_q <= 1'b0;
         pce_timer_q <= '0;
      end else if (pce_set) begin
         pce_q <= 1'b1;
         pce_timer_q <= PCE_WINDOW;
      end else if (pce_q && (sel_write || pce_timer_q == 3'h1)) begin
         pce_q <= 1'b0;
         pce_timer_q <= '0;
      end else if (pce_q) begin
         pce_timer_q <= pce_timer_q - 3'h1;
      end
   end

   // Division select: fuse value at start, then only through the unlock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_q <= SEL_RESET_DIV1;
      end else if (st_q == ST_CAPTURE) begin
         sel_q <= fuses.div8_programmed ? SEL_RESET_DIV8 : SEL_RESET_DIV1;
      end else if (sel_accept) begin
         sel_q <= bus.wdata[3:0];
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (rd_hit) begin
         rdata_q <= {pce_q, 3'h0, sel_q};
      end else begin
         rdata_q <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Divider and outputs

   power2_divider #(
      .SEL_W(4),
      .CNT_W(8)
   ) power2_divider_inst (
      .clock(clock),
      .rst(rst),
      .run(st_q == ST_RUN),
      .src_tick(src_tick),
      .load_init(st_q == ST_CAPTURE),
      .init_sel(fuses.div8_programmed ? SEL_RESET_DIV8 : SEL_RESET_DIV1),
      .new_valid(sel_accept),
      .new_sel(bus.wdata[3:0]),
      .div_tick(div_tick),
      .active_sel(active_sel),
      .switch_busy(switch_busy)
   );

   // One divided tick feeds all three clock domains
   assign sys_ticks.io_tick = div_tick;
   assign sys_ticks.cpu_tick = div_tick;
   assign sys_ticks.flash_tick = div_tick;
   assign reg_rdata = rdata_q;
   assign clock_running = (st_q == ST_RUN);
   assign config_error = (st_q == ST_HALT);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_pce_set_clean: assert property (@(posedge clock) disable iff (rst)
      $rose(pce_q) |-> $past(bus.write) && $past(bus.wdata) == UNLOCK_VALUE)
      else $error("change enable set by a write with other bits set");

   chk_pce_timeout: assert property (@(posedge clock) disable iff (rst)
      $rose(pce_q) |-> ##[1:4] !pce_q)
      else $error("change enable outlived its four-cycle window");

   chk_pce_sel_clear: assert property (@(posedge clock) disable iff (rst)
      sel_write |=> !pce_q)
      else $error("change enable kept after select write");

   chk_pce_norestart: assert property (@(posedge clock) disable iff (rst)
      pce_q && unlock_hit && pce_timer_q > 3'h1 |=>
         pce_q && pce_timer_q == $past(pce_timer_q) - 3'h1)
      else $error("rewrite restarted or cleared the window");

   chk_sel_locked: assert property (@(posedge clock) disable iff (rst)
      st_q != ST_CAPTURE && !sel_accept |=> sel_q == $past(sel_q))
      else $error("select changed without unlock");

   chk_sel_accept: assert property (@(posedge clock) disable iff (rst)
      sel_accept |=> sel_q == $past(bus.wdata[3:0]) && !pce_q)
      else $error("unlocked select write not taken");

   chk_reset_value: assert property (@(posedge clock) disable iff (rst)
      st_q == ST_CAPTURE |=> sel_q == (cfg_q.div8_programmed ? SEL_RESET_DIV8 : SEL_RESET_DIV1))
      else $error("select reset value does not follow fuse");

   chk_source_pick: assert property (@(posedge clock) disable iff (rst)
      st_q != ST_CAPTURE && cfg_q.source_sel == SRC_EXTERNAL |->
         src_tick == (ext_clock_pin && !$past(ext_clock_pin)))
      else $error("external source edge not followed");

   chk_lp_pick: assert property (@(posedge clock) disable iff (rst)
      st_q != ST_CAPTURE && cfg_q.source_sel == SRC_LOW_POWER |->
         src_tick == (low_power_osc && !$past(low_power_osc)))
      else $error("low-power source edge not followed");

   chk_reset_ticks: assert property (@(posedge clock) disable iff (rst)
      st_q == ST_RESET_TICKS && cfg_ok && src_tick && tick_cnt_q == RESET_TICKS - 4'h1
         && cfg_q.startup_sel == SUT_SHORT |=> st_q == ST_RUN)
      else $error("short start-up did not finish after 14 cycles");

   chk_wake_six: assert property (@(posedge clock) disable iff (rst)
      st_q == ST_WAKE && src_tick && tick_cnt_q == WAKE_TICKS - 4'h1 |=> st_q == ST_RUN)
      else $error("wake did not finish after six source cycles");

   chk_no_tick_stopped: assert property (@(posedge clock) disable iff (rst)
      st_q != ST_RUN ##1 st_q != ST_RUN |-> !div_tick)
      else $error("divided tick outside running state");

   cov_unlock_change: cover property (@(posedge clock) disable iff (rst)
      pce_set ##[1:4] sel_accept);
   cov_pce_timeout: cover property (@(posedge clock) disable iff (rst)
      pce_set ##1 !sel_write [*4] ##1 !pce_q);
   cov_wake: cover property (@(posedge clock) disable iff (rst)
      st_q == ST_WAKE ##1 st_q == ST_RUN);
   cov_switch: cover property (@(posedge clock) disable iff (rst)
      switch_busy ##1 !switch_busy);

endmodule : system_clock_select_prescaler
`default_nettype wire

// [tb/src_model.sv]
// Free-running clock source standing in for the external pin or the low-power oscillator
`timescale 1ns/1ps
`default_nettype none
module src_model #(
   parameter int HALF_NS = 115
) (
   // Oscillator output
   output logic osc_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Fixed half period, so cycle-to-cycle change stays far below the 2% limit
   initial begin
      osc_out = 1'b0;
      forever #(HALF_NS) osc_out <= ~osc_out;
   end
endmodule : src_model
`default_nettype wire

// [tb/tb_system_clock_select_prescaler.sv]
// Self-checking bench for the clock select and prescaler block
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_select_prescaler import clkctl_pkg::*;;
   localparam int EXT_HALF = 115;
   localparam int LP_HALF = 330;
   logic clock = 1'b0;
   logic rst = 1'b1;
   fuse_cfg_t fuses = '0;
   logic power_down = 1'b0;
   reg_req_t bus = '0;
   logic [7:0] reg_rdata;
   clk_ticks_t sys_ticks;
   logic clock_running, config_error, ext_pin, lp_osc, src_now, src_q = 1'b0;
   logic [3:0] active_sel;
   int fails = 0;
   int n_tests = 0;
   int gap = 0;
   int last_gap = 0;
   int min_gap = 0;
   int src_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, sources and device
   always #25 clock = ~clock;
   src_model #(.HALF_NS(EXT_HALF)) ext_inst (.osc_out(ext_pin));
   src_model #(.HALF_NS(LP_HALF)) lp_inst (.osc_out(lp_osc));
   system_clock_select_prescaler #(.EXT_FAST_DELAY(200), .EXT_SLOW_DELAY(400),
      .LP_FAST_DELAY(300), .LP_SLOW_DELAY(500)) system_clock_select_prescaler_inst (
      .clock(clock), .rst(rst), .fuses(fuses), .ext_clock_pin(ext_pin), .low_power_osc(lp_osc),
      .power_down(power_down), .bus(bus), .reg_rdata(reg_rdata), .sys_ticks(sys_ticks),
      .clock_running(clock_running), .config_error(config_error), .active_sel(active_sel));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare tasks and verdict
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic check_range(input int got, input int lo, input int hi, input string what);
      n_tests++;
      if (got < lo || got > hi) begin
         fails++;
         $display("ERROR %0t %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : check_range
   task automatic print_verdict();
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   // Source edge counter and divided tick monitor
   always @(posedge clock) begin
      src_now = (fuses.source_sel == SRC_LOW_POWER) ? lp_osc : ext_pin;
      if (src_now && !src_q) begin
         gap++;
         src_cnt++;
      end
      src_q = src_now;
      if (sys_ticks.io_tick === 1'b1) begin
         check({5'h00, sys_ticks}, 8'h07, "tick domains differ");
         last_gap = gap;
         if (gap < min_gap) min_gap = gap;
         gap = 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Register port tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge clock);
   endtask : wr
   task automatic idle(input int n);
      bus <= '0;
      repeat (n) @(posedge clock);
   endtask : idle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      bus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      bus <= '0;
      #1 check(reg_rdata, exp, what);
      @(posedge clock);
   endtask : rd
   task automatic wait_ticks(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 4000) begin
         @(posedge clock);
         k++;
         if (sys_ticks.io_tick === 1'b1) n--;
      end
      @(posedge clock); // Lets the monitor log the last gap first
      check_range(n, 0, 0, "ticks missing");
   endtask : wait_ticks
   task automatic hold_reset(input logic [3:0] s, input logic [1:0] t, input logic d);
      rst <= 1'b1;
      fuses <= '{source_sel: s, startup_sel: t, div8_programmed: d};
      repeat (12) @(posedge clock);
      rst <= 1'b0;
   endtask : hold_reset
   // Start-up time from reset and the fuse-chosen reset value of the select field
   task automatic start(input logic [3:0] s, input logic [1:0] t, input logic d, input int dly);
      int k;
      int base;
      int per;
      per = (s == SRC_LOW_POWER) ? 2 * LP_HALF : 2 * EXT_HALF;
      base = dly + 13 * per / 50;
      hold_reset(s, t, d);
      k = 0;
      while (clock_running !== 1'b1 && k < 3000) begin
         @(posedge clock);
         k++;
      end
      check_range(k, base, dly + 14 * per / 50 + 6, "start-up cycles");
      rd(PRESCALE_OFFSET, {4'h0, d ? SEL_RESET_DIV8 : SEL_RESET_DIV1}, "reset select");
   endtask : start
   // Unlock then write a select value in the next cycle
   task automatic change(input logic [7:0] v);
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      wr(PRESCALE_OFFSET, v);
      idle(1);
   endtask : change
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #(60000 * 50);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      start(SRC_EXTERNAL, SUT_SHORT, 1'b1, 0);
      start(SRC_EXTERNAL, SUT_FAST, 1'b0, 200);
      start(SRC_EXTERNAL, SUT_SLOW, 1'b1, 400);
      start(SRC_LOW_POWER, SUT_SHORT, 1'b0, 0);
      start(SRC_LOW_POWER, SUT_FAST, 1'b1, 300);
      start(SRC_LOW_POWER, SUT_SLOW, 1'b0, 500);
      wait_ticks(3);
      check_range(last_gap, 1, 1, "low-power div1");
      hold_reset(4'hF, SUT_SHORT, 1'b0);
      repeat (300) @(posedge clock);
      check({6'h00, config_error, clock_running}, 8'h02, "bad source");
      hold_reset(SRC_EXTERNAL, SUT_RESERVED, 1'b0);
      repeat (300) @(posedge clock);
      check({6'h00, config_error, clock_running}, 8'h02, "reserved start-up");
      start(SRC_EXTERNAL, SUT_SHORT, 1'b1, 0);
      rd(8'h01, 8'h00, "unmapped read");
      wait_ticks(3);
      check_range(last_gap, 8, 8, "div8 period");
      check({4'h0, active_sel}, 8'h03, "active select");
      wr(PRESCALE_OFFSET, 8'h05);
      wr(PRESCALE_OFFSET, 8'h81);
      wr(PRESCALE_OFFSET, 8'h05);
      idle(1);
      rd(PRESCALE_OFFSET, 8'h03, "locked writes");
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      rd(PRESCALE_OFFSET, 8'h83, "change enable set");
      wr(PRESCALE_OFFSET, 8'h01);
      idle(1);
      min_gap = 999;
      rd(PRESCALE_OFFSET, 8'h01, "select written");
      wait_ticks(2);
      check_range(last_gap, 2, 2, "new period in two edges");
      wait_ticks(3);
      check_range(min_gap, 2, 8, "intermediate period");
      change(8'h08);
      min_gap = 999;
      wait_ticks(3);
      check_range(last_gap, 256, 256, "div256 period");
      check_range(min_gap, 2, 256, "no short period");
      change(8'h09);
      rd(PRESCALE_OFFSET, 8'h08, "reserved code");
      change(8'h00);
      wait_ticks(3);
      check_range(last_gap, 1, 1, "div1 period");
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      rd(PRESCALE_OFFSET, 8'h80, "window cycle 1");
      rd(PRESCALE_OFFSET, 8'h80, "window cycle 3");
      rd(PRESCALE_OFFSET, 8'h00, "window closed");
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      idle(4);
      wr(PRESCALE_OFFSET, 8'h02);
      idle(1);
      rd(PRESCALE_OFFSET, 8'h00, "late select");
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      idle(1);
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      idle(1);
      rd(PRESCALE_OFFSET, 8'h80, "rewrite keeps bit");
      rd(PRESCALE_OFFSET, 8'h00, "no restart");
      wr(PRESCALE_OFFSET, UNLOCK_VALUE);
      idle(3);
      wr(PRESCALE_OFFSET, 8'h72);
      idle(1);
      rd(PRESCALE_OFFSET, 8'h02, "fourth cycle select");
      wait_ticks(3);
      check_range(last_gap, 4, 4, "div4 period");
      power_down <= 1'b1;
      repeat (10) @(posedge clock);
      check({7'h00, clock_running}, 8'h00, "sleeping");
      power_down <= 1'b0;
      src_cnt = 0;
      while (clock_running !== 1'b1 && src_cnt < 40) @(posedge clock);
      check_range(src_cnt, 6, 7, "wake edges");
      wait_ticks(3);
      check_range(last_gap, 4, 4, "period after wake");
      print_verdict();
   end
endmodule : tb_system_clock_select_prescaler
`default_nettype wire
